// ### hdl/scp_pkg.sv
// package: constants and carrier types for the system clock source and pll control
package scp_pkg;
    // register byte offsets
    localparam logic [7:0] SCP_OFS_CW1 = 8'h00;
    localparam logic [7:0] SCP_OFS_CW2 = 8'h04;
    localparam logic [7:0] SCP_OFS_STAT = 8'h08;
    // field positions
    localparam int SCP_CLKDIS_BIT = 4;
    localparam int SCP_MULT_LSB = 3;
    localparam int SCP_MULT_MSB = 7;
    localparam int SCP_VCO_BIT = 2;
    localparam int SCP_ST_PLL_BIT = 0;
    localparam int SCP_ST_OSC_BIT = 1;
    localparam int SCP_ST_OFF_BIT = 2;
    localparam int SCP_ST_LOCK_BIT = 3;
    localparam int SCP_ST_XSEL_BIT = 4;
    // multiplier range that engages the pll
    localparam logic [4:0] SCP_MULT_MIN = 5'h04;
    localparam logic [4:0] SCP_MULT_MAX = 5'h14;
    // reset values
    localparam logic [31:0] SCP_CW1_RST = 32'h0000_0000;
    localparam logic [31:0] SCP_CW2_RST = 32'h0000_0000;
    // timing
    localparam int SCP_CLK_HZ = 10_000_000;
    localparam int SCP_LOCK_TIME_MS = 1;
    localparam int SCP_LOCK_CYC = SCP_LOCK_TIME_MS * (SCP_CLK_HZ / 1000);
    // synchroniser lanes
    localparam int SCP_SYNC_W = 3;
    localparam int SCP_SY_XSEL = 0;
    localparam int SCP_SY_HWRST = 1;
    localparam int SCP_SY_OSC = 2;

    // clock control outputs toward the analog clock section
    typedef struct packed {
        logic osc_enable;
        logic crystal_out;
        logic sysclk_off;
        logic pll_enable;
        logic pll_bypass;
        logic [4:0] pll_mult;
        logic vco_range;
        logic lock_settling;
    } scp_clk_ctrl_t;

    // ahb-lite slave answer
    typedef struct packed {
        logic [31:0] hrdata;
        logic hreadyout;
        logic hresp;
    } scp_ahb_rsp_t;

    // whole state of the top module
    typedef struct packed {
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic [31:0] cw1;
        logic [31:0] cw2;
        logic [15:0] lock_cnt;
        scp_clk_ctrl_t ctrl;
        scp_ahb_rsp_t rsp;
    } scp_state_t;
endpackage : scp_pkg

// ### hdl/scp_sync3.sv
// three-stage pin synchroniser; a change is taken once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module scp_sync3 #(
    parameter int W = 3
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // asynchronous pins in, clean levels out
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;
    logic [W-1:0] lvl_r;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_lane
            // stage one feeds only stage two, so no logic sees a metastable value
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1_r[i] <= 1'b0;
                    s2_r[i] <= 1'b0;
                    s3_r[i] <= 1'b0;
                    lvl_r[i] <= 1'b0;
                end else begin
                    s1_r[i] <= pin_in[i];
                    s2_r[i] <= s1_r[i];
                    s3_r[i] <= s2_r[i];
                    if (s2_r[i] == s3_r[i]) begin
                        lvl_r[i] <= s3_r[i];
                    end
                end
            end
        end
    endgenerate

    assign level_out = lvl_r;
endmodule : scp_sync3
`default_nettype wire

// ### hdl/scp_clk_ctrl.sv
// system clock source select and pll multiplier control with an ahb-lite register slave
// Summary of operation
// - the clock mode comes from the oscillator-select pin, the clock-disable bit and the multiplier field.
// - a high oscillator-select pin turns the on-chip crystal oscillator on while the clock-disable bit is clear.
// - the oscillator signal is buffered and that buffered reference is driven on the crystal output while the oscillator is enabled; otherwise it is held low.
// - a multiplier of 4 to 20 makes the pll multiply the reference by that value.
// - a multiplier below 4 or above 20 bypasses the pll and passes the reference straight through.
// - while bypassed the pll is powered down.
// - the multiplier field is decoded with no regard to the clock-disable bit.
// - one vco range bit at bit 2 of the second control word sets the vco range.
// - a high hardware reset pin returns every control register to its default.
`timescale 1ns/1ps
`default_nettype none
module scp_clk_ctrl #(
    parameter int LOCK_CYCLES = scp_pkg::SCP_LOCK_CYC
) (
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output scp_pkg::scp_ahb_rsp_t ahb_rsp,
    // device pins
    input wire logic xtal_osc_select,
    input wire logic hw_reset,
    input wire logic osc_or_reference_in,
    // controls toward the oscillator and pll
    output scp_pkg::scp_clk_ctrl_t clk_ctrl
);
    import scp_pkg::*;

    scp_state_t s_r;
    scp_state_t s_nxt;
    logic [SCP_SYNC_W-1:0] pins_raw;
    logic [SCP_SYNC_W-1:0] pins;
    logic [4:0] mult;
    logic in_range;
    logic osc_on;
    logic clk_off;
    logic addr_phase;

    // pins come from outside the clock domain
    assign pins_raw = {osc_or_reference_in, hw_reset, xtal_osc_select};

    scp_sync3 #(.W(SCP_SYNC_W)) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .pin_in(pins_raw),
        .level_out(pins)
    );

    assign addr_phase = hsel & hready & htrans[1];

    // next state: register writes, mode decode, read data
    always_comb begin
        s_nxt = s_r;
        // data phase of a write; the word lands one cycle after its address
        if (s_r.ap_valid && s_r.ap_write) begin
            case (s_r.ap_addr)
                SCP_OFS_CW1: begin
                    s_nxt.cw1 = hwdata;
                end
                SCP_OFS_CW2: begin
                    s_nxt.cw2 = hwdata;
                end
                default: begin
                    s_nxt.cw1 = s_r.cw1;
                end
            endcase
        end
        // hardware reset pin overrides any write in the same cycle
        if (pins[SCP_SY_HWRST]) begin
            s_nxt.cw1 = SCP_CW1_RST;
            s_nxt.cw2 = SCP_CW2_RST;
        end
        // decode from the values that will stand next cycle
        mult = s_nxt.cw2[SCP_MULT_MSB:SCP_MULT_LSB];
        in_range = (mult >= SCP_MULT_MIN) && (mult <= SCP_MULT_MAX);
        clk_off = s_nxt.cw1[SCP_CLKDIS_BIT];
        osc_on = pins[SCP_SY_XSEL] & ~clk_off;
        s_nxt.ctrl.osc_enable = osc_on;
        // buffered reference only while the oscillator runs; otherwise crystal_out is held low
        s_nxt.ctrl.crystal_out = osc_on & pins[SCP_SY_OSC];
        s_nxt.ctrl.sysclk_off = clk_off;
        s_nxt.ctrl.pll_enable = in_range;
        s_nxt.ctrl.pll_bypass = ~in_range;
        // bypassed pll gets a zero factor so it holds nothing stale
        s_nxt.ctrl.pll_mult = in_range ? mult : 5'h00;
        s_nxt.ctrl.vco_range = s_nxt.cw2[SCP_VCO_BIT];
        // settle timer restarts on any new factor or on pll power-up
        if (in_range && (!s_r.ctrl.pll_enable || mult != s_r.ctrl.pll_mult)) begin
            s_nxt.lock_cnt = 16'(LOCK_CYCLES);
        end else if (!in_range) begin
            s_nxt.lock_cnt = 16'h0000;
        end else if (s_r.lock_cnt != 16'h0000) begin
            s_nxt.lock_cnt = s_r.lock_cnt - 16'h0001;
        end
        s_nxt.ctrl.lock_settling = (s_nxt.lock_cnt != 16'h0000);
        // address phase capture
        s_nxt.ap_valid = addr_phase;
        s_nxt.ap_write = hwrite;
        s_nxt.ap_addr = haddr[7:0];
        // read data staged at the address edge, showing any write just landed
        if (addr_phase && !hwrite) begin
            case (haddr[7:0])
                SCP_OFS_CW1: begin
                    s_nxt.rsp.hrdata = s_nxt.cw1;
                end
                SCP_OFS_CW2: begin
                    s_nxt.rsp.hrdata = s_nxt.cw2;
                end
                SCP_OFS_STAT: begin
                    s_nxt.rsp.hrdata = 32'h0000_0000;
                    s_nxt.rsp.hrdata[SCP_ST_PLL_BIT] = s_nxt.ctrl.pll_enable;
                    s_nxt.rsp.hrdata[SCP_ST_OSC_BIT] = s_nxt.ctrl.osc_enable;
                    s_nxt.rsp.hrdata[SCP_ST_OFF_BIT] = s_nxt.ctrl.sysclk_off;
                    s_nxt.rsp.hrdata[SCP_ST_LOCK_BIT] = s_nxt.ctrl.lock_settling;
                    s_nxt.rsp.hrdata[SCP_ST_XSEL_BIT] = pins[SCP_SY_XSEL];
                end
                default: begin
                    s_nxt.rsp.hrdata = 32'h0000_0000; // unmapped reads zero
                end
            endcase
        end
        // zero wait states, always okay
        s_nxt.rsp.hreadyout = 1'b1;
        s_nxt.rsp.hresp = 1'b0;
    end

    // single state register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_r <= '0;
            s_r.cw1 <= SCP_CW1_RST;
            s_r.cw2 <= SCP_CW2_RST;
            s_r.ctrl.pll_bypass <= 1'b1;
            s_r.rsp.hreadyout <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ahb_rsp = s_r.rsp;
    assign clk_ctrl = s_r.ctrl;
endmodule : scp_clk_ctrl
`default_nettype wire

// ### tb/scp_clk_ctrl_assertions.sv
// checker: clock source and pll control relations
`timescale 1ns/1ps
`default_nettype none
module scp_clk_ctrl_assertions (
    // clock, reset and pins
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic xtal_osc_select,
    input wire logic hw_reset,
    // controls
    input wire scp_pkg::scp_clk_ctrl_t clk_ctrl
);
    import scp_pkg::*;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // decode relations between control outputs
    a_bypass_inverse: assert property (clk_ctrl.pll_bypass == !clk_ctrl.pll_enable)
        else $error("bypass is not the inverse of enable");
    a_mult_in_range: assert property (clk_ctrl.pll_enable |->
        clk_ctrl.pll_mult inside {[SCP_MULT_MIN:SCP_MULT_MAX]})
        else $error("pll on with multiplier out of range");
    a_bypass_mult_zero: assert property (clk_ctrl.pll_bypass |-> clk_ctrl.pll_mult == 5'h00)
        else $error("bypassed pll still has a multiplier");
    a_off_kills_osc: assert property (clk_ctrl.sysclk_off |-> !clk_ctrl.osc_enable)
        else $error("oscillator on while clock disabled");
    a_xtal_gated: assert property (!clk_ctrl.osc_enable |-> !clk_ctrl.crystal_out)
        else $error("crystal output moves with oscillator off");
    // settling flag must come up within a cycle of pll power-up
    a_settle_on_up: assert property ($rose(clk_ctrl.pll_enable) |-> ##[0:1] clk_ctrl.lock_settling)
        else $error("no settling flag after pll power-up");
    // slow pin paths: sync latency is covered by the repetition count
    a_osc_needs_pin: assert property ((!xtal_osc_select)[*6] |-> !clk_ctrl.osc_enable)
        else $error("oscillator on with select pin low");
    a_hwrst_clears: assert property (hw_reset[*8] |->
        !clk_ctrl.pll_enable && !clk_ctrl.sysclk_off && !clk_ctrl.vco_range)
        else $error("hardware reset left control bits set");
    c_pll_on: cover property (clk_ctrl.pll_enable);
    c_osc_on: cover property (clk_ctrl.osc_enable && clk_ctrl.crystal_out);
    c_settled: cover property ($fell(clk_ctrl.lock_settling));
endmodule : scp_clk_ctrl_assertions
bind scp_clk_ctrl scp_clk_ctrl_assertions u_chk (.hclk(hclk), .hresetn(hresetn),
    .xtal_osc_select(xtal_osc_select), .hw_reset(hw_reset), .clk_ctrl(clk_ctrl));
`default_nettype wire

// ### tb/scp_ref_osc.sv
// partner: reference oscillator driving the reference input
`timescale 1ns/1ps
`default_nettype none
module scp_ref_osc (
    // control from the bench
    input wire logic run,
    input wire logic slow,
    // reference out
    output logic ref_out
);
    // free-running source; stands low when stopped so no stale level lingers
    // one process owns the output, so start level and toggling never race
    initial begin
        ref_out = 1'b0;
        forever begin
            #(slow ? 730 : 170);
            ref_out = run ? ~ref_out : 1'b0;
        end
    end
endmodule : scp_ref_osc
`default_nettype wire

// ### tb/scp_clk_ctrl_test.sv
// testbench: clock control through the register bus and pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin num_errors++; \
    $display("mismatch %s exp %h got %h", n, e, a); end end
module scp_clk_ctrl_test;
    import scp_pkg::*;
    localparam int LC = 20;
    // status words expected with the pll on, oscillator running and select pin high
    localparam logic [31:0] ST_ON = 32'(1 << SCP_ST_PLL_BIT | 1 << SCP_ST_OSC_BIT |
        1 << SCP_ST_XSEL_BIT);
    localparam logic [31:0] ST_LOCK = 32'(1 << SCP_ST_LOCK_BIT);
    logic hclk = 0, hresetn = 0, hwrite = 0, xtal_osc_select = 0, hw_reset = 0;
    logic run = 1, slow = 0, ref_in, en;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = 0, hwdata = 0, q;
    logic [4:0] tbl [6] = '{5'h03, 5'h04, 5'h14, 5'h15, 5'h00, 5'h1f};
    int num_errors = 0, check_count = 0, cyc = 0;
    scp_ahb_rsp_t ahb_rsp;
    scp_clk_ctrl_t clk_ctrl;
    scp_ref_osc u_osc (.run(run), .slow(slow), .ref_out(ref_in));
    scp_clk_ctrl #(.LOCK_CYCLES(LC)) u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(ahb_rsp.hreadyout), .ahb_rsp(ahb_rsp), .xtal_osc_select(xtal_osc_select),
        .hw_reset(hw_reset), .osc_or_reference_in(ref_in), .clk_ctrl(clk_ctrl));
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick
    // one single transfer: address phase, then data phase, each held until hready
    task automatic bus(input logic wr, input logic [31:0] a, d, output logic [31:0] r);
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'b10;
        do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (ahb_rsp.hreadyout !== 1'b1);
        r = ahb_rsp.hrdata;
    endtask : bus
    task automatic t_reset;
        bus(0, SCP_OFS_CW1, 0, q);
        `CHK("cw1", SCP_CW1_RST, q)
        bus(0, SCP_OFS_CW2, 0, q);
        `CHK("cw2", SCP_CW2_RST, q)
        bus(0, 32'h0000_000c, 0, q);
        `CHK("unmapped", 32'h0, q)
        `CHK("bypass", 1'b1, clk_ctrl.pll_bypass)
        `CHK("hresp", 1'b0, ahb_rsp.hresp)
        $display("test reset done");
    endtask : t_reset
    // edges of the multiplier range, with the vco bit alternating
    task automatic t_mult;
        foreach (tbl[i]) begin
            en = (tbl[i] >= SCP_MULT_MIN) && (tbl[i] <= SCP_MULT_MAX);
            bus(1, SCP_OFS_CW2, {24'h0, tbl[i], i[0], 2'b00}, q);
            tick(2);
            `CHK("pll_enable", en, clk_ctrl.pll_enable)
            `CHK("pll_mult", en ? tbl[i] : 5'h00, clk_ctrl.pll_mult)
            `CHK("vco_range", i[0], clk_ctrl.vco_range)
            bus(0, SCP_OFS_CW2, 0, q);
            `CHK("cw2 back", {24'h0, tbl[i], i[0], 2'b00}, q)
        end
        $display("test multiplier done");
    endtask : t_mult
    task automatic t_clkdis;
        bus(1, SCP_OFS_CW2, 32'h0000_0040, q);
        bus(1, SCP_OFS_CW1, 32'h0000_0010, q);
        xtal_osc_select <= 1'b1;
        tick(8);
        `CHK("osc_off", 1'b0, clk_ctrl.osc_enable)
        `CHK("sysclk_off", 1'b1, clk_ctrl.sysclk_off)
        `CHK("mult kept", 5'h08, clk_ctrl.pll_mult)
        bus(1, SCP_OFS_CW1, 0, q);
        tick(3);
        `CHK("osc_on", 1'b1, clk_ctrl.osc_enable)
        en = 0;
        q = 32'h0000_0000;
        repeat (20) begin
            @(posedge hclk);
            en = en | (clk_ctrl.crystal_out === 1'b1);
            q[0] = q[0] | (clk_ctrl.crystal_out === 1'b0);
        end
        `CHK("crystal toggles", 1'b1, en)
        `CHK("crystal falls", 1'b1, q[0])
        // a stopped reference must leave the buffered output low
        run <= 1'b0;
        tick(8);
        `CHK("crystal idle", 1'b0, clk_ctrl.crystal_out)
        run <= 1'b1;
        $display("test clock disable done");
    endtask : t_clkdis
    task automatic t_lock;
        slow <= 1'b1;
        bus(1, SCP_OFS_CW2, 0, q);
        // factor 4 keeps the multiplied reference well under the pll ceiling
        bus(1, SCP_OFS_CW2, 32'h0000_0020, q);
        tick(3);
        `CHK("settling", 1'b1, clk_ctrl.lock_settling)
        bus(0, SCP_OFS_STAT, 0, q);
        `CHK("status settling", ST_ON | ST_LOCK, q)
        tick(LC + 6);
        `CHK("settled", 1'b0, clk_ctrl.lock_settling)
        bus(0, SCP_OFS_STAT, 0, q);
        `CHK("status settled", ST_ON, q)
        $display("test lock done");
    endtask : t_lock
    task automatic t_hwrst;
        bus(1, SCP_OFS_CW1, 32'h0000_0010, q);
        bus(1, SCP_OFS_CW2, 32'h0000_0054, q);
        hw_reset <= 1'b1;
        tick(10);
        hw_reset <= 1'b0;
        tick(6);
        `CHK("pll after hw", 1'b0, clk_ctrl.pll_enable)
        `CHK("off after hw", 1'b0, clk_ctrl.sysclk_off)
        `CHK("vco after hw", 1'b0, clk_ctrl.vco_range)
        bus(0, SCP_OFS_CW2, 0, q);
        `CHK("cw2 after hw", SCP_CW2_RST, q)
        $display("test hardware reset done");
    endtask : t_hwrst
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    // 10 MHz clock
    initial begin
        forever #50 hclk = ~hclk;
    end
    // hang guard, far above the under two hundred cycles the run needs
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            finish_test();
        end
    end
    initial begin
        tick(16);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_mult();
        t_clkdis();
        t_lock();
        t_hwrst();
        finish_test();
    end
endmodule : scp_clk_ctrl_test
`default_nettype wire
